/* inc/erva_pkg.sv */
// Constants for the error log and channel arbitration register slice
package erva_pkg;
  localparam int          ERVA_ADDR_W        = 12;
  localparam int          ERVA_TBL_WORDS     = 4;
  // Register byte addresses
  localparam logic [11:0] ERVA_ADV_ERR_CAP   = 12'h118;
  localparam logic [11:0] ERVA_HDR_LOG0      = 12'h11c;
  localparam logic [11:0] ERVA_HDR_LOG1      = 12'h120;
  localparam logic [11:0] ERVA_HDR_LOG2      = 12'h124;
  localparam logic [11:0] ERVA_HDR_LOG3      = 12'h128;
  localparam logic [11:0] ERVA_VC_CAP_HDR    = 12'h140;
  localparam logic [11:0] ERVA_PORT_CAP_ONE  = 12'h144;
  localparam logic [11:0] ERVA_PORT_CAP_TWO  = 12'h148;
  localparam logic [11:0] ERVA_PORT_CTRL     = 12'h14c;
  localparam logic [11:0] ERVA_ARB_TBL_BASE  = 12'h170;
  localparam logic [11:0] ERVA_ARB_TBL_LAST  = 12'h17c;
  // Field positions
  localparam int          ERVA_FEP_LSB       = 0;
  localparam int          ERVA_ECRC_GEN_CAP  = 5;
  localparam int          ERVA_ECRC_GEN_EN   = 6;
  localparam int          ERVA_ECRC_CHK_CAP  = 7;
  localparam int          ERVA_ECRC_CHK_EN   = 8;
  localparam int          ERVA_LOAD_BIT      = 0;
  localparam int          ERVA_SEL_LSB       = 1;
  localparam int          ERVA_TBL_STAT_BIT  = 16;
  // Fixed capability values
  localparam logic [15:0] ERVA_VC_CAP_ID     = 16'h0002;
  localparam logic [3:0]  ERVA_VC_CAP_VER    = 4'h1;
  localparam logic [11:0] ERVA_VC_NEXT_PTR   = 12'h20c;
  localparam logic [1:0]  ERVA_REF_CLK       = 2'h0;
  localparam logic [1:0]  ERVA_ENTRY_SIZE    = 2'h2;
  localparam logic [7:0]  ERVA_ARB_CAP_ON    = 8'h03;
  localparam logic [7:0]  ERVA_ARB_CAP_OFF   = 8'h00;
  localparam logic [7:0]  ERVA_TBL_OFS_ON    = 8'h03;
  localparam logic [7:0]  ERVA_TBL_OFS_OFF   = 8'h00;
  // Reset values and the select limit
  localparam logic [4:0]  ERVA_FEP_RESET     = 5'h00;
  localparam logic [1:0]  ERVA_EXT_HI_RESET  = 2'h0;
  localparam logic [2:0]  ERVA_LP_RESET      = 3'h0;
  localparam logic [2:0]  ERVA_SEL_RESET     = 3'h0;
  localparam logic [2:0]  ERVA_SEL_MAX       = 3'h1;
  // Cycles the hardware takes to apply the table, one per 4-bit phase entry
  localparam int          ERVA_LOAD_CYCLES   = 32;
endpackage

/* inc/erva_load_if.sv */
// Handshake between the register slice and the table loader
`timescale 1ns/1ps
interface erva_load_if;
  logic start;
  logic busy;
  logic done;
  modport regs   (output start, input busy, input done);
  modport loader (input start, output busy, output done);
endinterface

/* src/erva_table_loader.sv */
// Multi-cycle arbitration table load sequencer
`timescale 1ns/1ps
module erva_table_loader #(
  parameter int LOAD_CYCLES = erva_pkg::ERVA_LOAD_CYCLES
) (
  // Clock and reset
  input wire logic   clock,
  input wire logic   reset,
  // Load handshake
  erva_load_if.loader ld
);
  import erva_pkg::*;

  typedef enum logic {ERVA_IDLE, ERVA_LOAD} erva_lstate_t;
  typedef struct packed {
    erva_lstate_t st;
    logic [7:0]   cnt;
    logic         done;
  } erva_lst_t;

  erva_lst_t s_reg;
  erva_lst_t s_next;

  always_comb begin
    s_next      = s_reg;
    s_next.done = 1'b0;
    unique case (s_reg.st)
      ERVA_IDLE: begin
        // Start requests are only offered while idle
        if (ld.start) begin
          s_next.st  = ERVA_LOAD;
          s_next.cnt = 8'(LOAD_CYCLES - 1);
        end
      end
      ERVA_LOAD: begin
        if (s_reg.cnt == 8'h00) begin
          s_next.st   = ERVA_IDLE;
          s_next.done = 1'b1;
        end else begin
          s_next.cnt = s_reg.cnt - 8'h01;
        end
      end
    endcase
    if (reset) begin
      s_next = '{st: ERVA_IDLE, cnt: 8'h00, done: 1'b0};
    end
  end

  always_ff @(posedge clock) begin
    s_reg <= s_next;
  end

  assign ld.busy = (s_reg.st == ERVA_LOAD);
  assign ld.done = s_reg.done;
endmodule

/* src/erva_regs.sv */
// Error log and port channel arbitration configuration registers
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
module erva_regs #(
  parameter int LOAD_CYCLES = erva_pkg::ERVA_LOAD_CYCLES
) (
  // Clock and resets
  input  wire logic                          clock,
  input  wire logic                          reset,
  input  wire logic                          power_on_reset,
  // Wishbone classic slave
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [erva_pkg::ERVA_ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic      [31:0]                   wb_dat_o,
  output logic                               wb_ack_o,
  // Strap and autoload
  input  wire logic                          second_channel_strap,
  input  wire logic                          eeprom_load_valid,
  input  wire logic [2:0]                    eeprom_ext_count,
  input  wire logic [2:0]                    eeprom_lp_count,
  // Error reporting
  input  wire logic                          err_valid,
  input  wire logic [4:0]                    err_index,
  input  wire logic                          err_masked,
  input  wire logic [127:0]                  err_header,
  input  wire logic                          err_log_release,
  output logic                               err_message,
  // Controls towards the port logic
  output logic                               ecrc_gen_enable,
  output logic                               ecrc_check_enable,
  output logic      [2:0]                    arb_select,
  output logic      [127:0]                  arb_table_applied,
  output logic                               arb_cap_valid,
  output logic                               table_load_busy
);
  import erva_pkg::*;

  typedef struct packed {
    logic                                sync1;
    logic                                sync2;
    logic                                strap_pending;
    logic [2:0]                          ext_count;
    logic [2:0]                          lp_count;
    logic                                ecrc_gen;
    logic                                ecrc_chk;
    logic [4:0]                          first_ptr;
    logic [127:0]                        hdr;
    logic                                logged;
    logic                                msg;
    logic [2:0]                          arb_sel;
    logic [ERVA_TBL_WORDS-1:0][31:0]     tbl;
    logic [ERVA_TBL_WORDS-1:0][31:0]     applied;
    logic                                tbl_status;
    logic                                start;
    logic                                ack;
    logic [31:0]                         dat;
  } erva_state_t;

  erva_state_t s_reg;
  erva_state_t s_next;
  erva_load_if ld();

  erva_table_loader #(
    .LOAD_CYCLES (LOAD_CYCLES)
  ) u_loader (
    .clock (clock),
    .reset (reset),
    .ld    (ld)
  );

  logic        req;
  logic        wr;
  logic [31:0] lane;
  logic [31:0] rdata;
  logic [31:0] wval;
  logic [1:0]  tidx;
  logic        tbl_hit;
  logic [2:0]  sel_w;

  function automatic logic [31:0] erva_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [31:0] mask);
    erva_merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  always_comb begin
    req     = wb_cyc_i && wb_stb_i && !s_reg.ack;
    wr      = req && wb_we_i;
    lane    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    tbl_hit = (wb_adr_i >= ERVA_ARB_TBL_BASE) && (wb_adr_i <= ERVA_ARB_TBL_LAST);
    tidx    = wb_adr_i[3:2];
    wval    = 32'h0000_0000;
    sel_w   = 3'h0;
    rdata   = 32'h0000_0000;
    // Read mux; unmapped addresses read zero and are still acknowledged
    unique case (wb_adr_i)
      ERVA_ADV_ERR_CAP: begin
        rdata[ERVA_FEP_LSB +: 5]   = s_reg.first_ptr;
        rdata[ERVA_ECRC_GEN_CAP]   = 1'b1;
        rdata[ERVA_ECRC_CHK_CAP]   = 1'b1;
        rdata[ERVA_ECRC_GEN_EN]    = s_reg.ecrc_gen;
        rdata[ERVA_ECRC_CHK_EN]    = s_reg.ecrc_chk;
      end
      ERVA_HDR_LOG0: rdata = s_reg.hdr[31:0];
      ERVA_HDR_LOG1: rdata = s_reg.hdr[63:32];
      ERVA_HDR_LOG2: rdata = s_reg.hdr[95:64];
      ERVA_HDR_LOG3: rdata = s_reg.hdr[127:96];
      ERVA_VC_CAP_HDR: begin
        rdata = {ERVA_VC_NEXT_PTR, ERVA_VC_CAP_VER, ERVA_VC_CAP_ID};
      end
      ERVA_PORT_CAP_ONE: begin
        rdata[2:0]   = s_reg.ext_count;
        rdata[6:4]   = s_reg.lp_count;
        rdata[9:8]   = ERVA_REF_CLK;
        rdata[11:10] = ERVA_ENTRY_SIZE;
      end
      ERVA_PORT_CAP_TWO: begin
        // Both fields follow the live count bit so autoload keeps them consistent
        rdata[7:0]   = s_reg.ext_count[0] ? ERVA_ARB_CAP_ON : ERVA_ARB_CAP_OFF;
        rdata[31:24] = s_reg.ext_count[0] ? ERVA_TBL_OFS_ON : ERVA_TBL_OFS_OFF;
      end
      ERVA_PORT_CTRL: begin
        rdata[ERVA_LOAD_BIT]     = 1'b0;
        rdata[ERVA_SEL_LSB +: 3] = s_reg.arb_sel;
        rdata[ERVA_TBL_STAT_BIT] = s_reg.tbl_status;
      end
      default: begin
        rdata = tbl_hit ? s_reg.tbl[tidx] : 32'h0000_0000;
      end
    endcase

    s_next       = s_reg;
    s_next.sync1 = second_channel_strap;
    s_next.sync2 = s_reg.sync1;
    s_next.ack   = req;
    s_next.msg   = 1'b0;
    s_next.start = 1'b0;
    if (req) begin
      s_next.dat = rdata;
    end

    // Strap taken one cycle after reset release, from the synchronised pin
    if (s_reg.strap_pending) begin
      s_next.strap_pending = 1'b0;
      s_next.ext_count     = {ERVA_EXT_HI_RESET, s_reg.sync2};
    end
    if (eeprom_load_valid) begin
      s_next.ext_count = eeprom_ext_count;
      s_next.lp_count  = eeprom_lp_count;
    end

    if (wr) begin
      unique case (wb_adr_i)
        ERVA_ADV_ERR_CAP: begin
          if (wb_sel_i[0]) begin
            s_next.ecrc_gen = wb_dat_i[ERVA_ECRC_GEN_EN];
          end
          if (wb_sel_i[1]) begin
            s_next.ecrc_chk = wb_dat_i[ERVA_ECRC_CHK_EN];
          end
        end
        ERVA_PORT_CTRL: begin
          if (wb_sel_i[0]) begin
            sel_w          = wb_dat_i[ERVA_SEL_LSB +: 3];
            s_next.arb_sel = (sel_w <= ERVA_SEL_MAX) ? sel_w : ERVA_SEL_RESET;
            // A load request while a load runs is dropped
            s_next.start   = wb_dat_i[ERVA_LOAD_BIT] && !ld.busy;
          end
        end
        default: begin
          if (tbl_hit) begin
            wval              = erva_merge(s_reg.tbl[tidx], wb_dat_i, lane);
            s_next.tbl[tidx]  = wval;
          end
        end
      endcase
    end

    // Completion clears the flag, but a table write in the same cycle wins
    if (ld.done) begin
      s_next.tbl_status = 1'b0;
      s_next.applied    = s_reg.tbl;
    end
    if (wr && tbl_hit && (wb_sel_i != 4'h0)) begin
      s_next.tbl_status = 1'b1;
    end

    // Release reopens the log; a new error in the same cycle is captured
    if (err_log_release) begin
      s_next.logged = 1'b0;
    end
    if (err_valid && !err_masked) begin
      s_next.msg = 1'b1;
      if (!s_reg.logged || err_log_release) begin
        s_next.logged    = 1'b1;
        s_next.first_ptr = err_index;
        s_next.hdr       = err_header;
      end
    end

    // Normal reset spares the sticky fields
    if (reset || power_on_reset) begin
      s_next.strap_pending = 1'b1;
      s_next.ext_count     = {ERVA_EXT_HI_RESET, 1'b0};
      s_next.lp_count      = ERVA_LP_RESET;
      s_next.msg           = 1'b0;
      s_next.arb_sel       = ERVA_SEL_RESET;
      s_next.tbl           = '0;
      s_next.applied       = '0;
      s_next.tbl_status    = 1'b0;
      s_next.start         = 1'b0;
      s_next.ack           = 1'b0;
      s_next.dat           = 32'h0000_0000;
    end
    if (power_on_reset) begin
      s_next.ecrc_gen  = 1'b0;
      s_next.ecrc_chk  = 1'b0;
      s_next.first_ptr = ERVA_FEP_RESET;
      s_next.hdr       = '0;
      s_next.logged    = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    s_reg <= s_next;
  end

  assign ld.start          = s_reg.start;
  assign wb_ack_o          = s_reg.ack;
  assign wb_dat_o          = s_reg.dat;
  assign err_message       = s_reg.msg;
  assign ecrc_gen_enable   = s_reg.ecrc_gen;
  assign ecrc_check_enable = s_reg.ecrc_chk;
  assign arb_select        = s_reg.arb_sel;
  assign arb_table_applied = s_reg.applied;
  assign arb_cap_valid     = (s_reg.lp_count != 3'h0);
  assign table_load_busy   = ld.busy;
endmodule

/* bench/erva_regs_checker.sv */
// Port-level assertions for the register slice
`timescale 1ns/1ps
module erva_regs_checker #(
  parameter int LOAD_CYCLES = erva_pkg::ERVA_LOAD_CYCLES
) (
  // Clock and resets
  input wire logic                               clock,
  input wire logic                               reset,
  input wire logic                               power_on_reset,
  // Bus
  input wire logic                               wb_cyc_i,
  input wire logic                               wb_stb_i,
  input wire logic                               wb_we_i,
  input wire logic [erva_pkg::ERVA_ADDR_W-1:0]   wb_adr_i,
  input wire logic [3:0]                         wb_sel_i,
  input wire logic [31:0]                        wb_dat_i,
  input wire logic                               wb_ack_o,
  // Events and controls
  input wire logic                               err_valid,
  input wire logic                               err_masked,
  input wire logic                               err_message,
  input wire logic                               ecrc_gen_enable,
  input wire logic                               ecrc_check_enable,
  input wire logic [2:0]                         arb_select,
  input wire logic [127:0]                       arb_table_applied,
  input wire logic                               table_load_busy
);
  import erva_pkg::*;
  logic       take;
  logic       ctl_wr;
  logic [7:0] busy_cnt_reg;
  default clocking @(posedge clock); endclocking
  default disable iff (reset || power_on_reset);
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign ctl_wr = take && wb_we_i && wb_adr_i == ERVA_PORT_CTRL && wb_sel_i[0];
  // Load length exceeds what a repetition may hold
  always_ff @(posedge clock) begin
    if (reset || power_on_reset || !table_load_busy) begin
      busy_cnt_reg <= 8'h00;
    end else begin
      busy_cnt_reg <= busy_cnt_reg + 8'h01;
    end
  end
  property p_ack_next; take |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack after request");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_gen_en;
    take && wb_we_i && wb_adr_i == ERVA_ADV_ERR_CAP && wb_sel_i[0]
      |=> ecrc_gen_enable == $past(wb_dat_i[6]);
  endproperty
  a_gen_en: assert property (p_gen_en) else $error("gen enable not written");
  property p_chk_en;
    take && wb_we_i && wb_adr_i == ERVA_ADV_ERR_CAP && wb_sel_i[1]
      |=> ecrc_check_enable == $past(wb_dat_i[8]);
  endproperty
  a_chk_en: assert property (p_chk_en) else $error("check enable not written");
  property p_err_msg; err_message |-> $past(err_valid && !err_masked); endproperty
  a_err_msg: assert property (p_err_msg) else $error("message without unmasked error");
  property p_sel;
    ctl_wr |=> arb_select == (($past(wb_dat_i[3:1]) > 3'h1) ? 3'h0 : $past(wb_dat_i[3:1]));
  endproperty
  a_sel: assert property (p_sel) else $error("select value wrong");
  property p_load_start; ctl_wr && wb_dat_i[0] && !table_load_busy |-> ##2 table_load_busy;
  endproperty
  a_load_start: assert property (p_load_start) else $error("load did not start");
  property p_busy_len; $fell(table_load_busy) |-> busy_cnt_reg == 8'(LOAD_CYCLES); endproperty
  a_busy_len: assert property (p_busy_len) else $error("load length wrong");
  // Completion pulse is registered, so the copy lands one edge after busy drops
  property p_applied;
    !$stable(arb_table_applied) |-> $past(table_load_busy, 2) && !$past(table_load_busy);
  endproperty
  a_applied: assert property (p_applied) else $error("table applied outside load end");
  property p_sticky;
    disable iff (power_on_reset) reset |=> $stable(ecrc_check_enable);
  endproperty
  a_sticky: assert property (p_sticky) else $error("sticky enable lost in reset");
endmodule

/* bench/erva_host_model.sv */
// Classic bus master standing in for configuration software
`timescale 1ns/1ps
module erva_host_model (
  // Clock
  input  wire logic        clock,
  // Bus master side
  output logic             wb_cyc_o,
  output logic             wb_stb_o,
  output logic             wb_we_o,
  output logic [11:0]      wb_adr_o,
  output logic [3:0]       wb_sel_o,
  output logic [31:0]      wb_dat_o,
  input  wire logic        wb_ack_i,
  input  wire logic [31:0] wb_dat_i
);
  initial begin
    {wb_cyc_o, wb_stb_o, wb_we_o} = 3'h0;
    {wb_adr_o, wb_sel_o, wb_dat_o} = 48'h0;
  end
  // Caller enters just after a rising edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] q);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= w;
    wb_adr_o <= a;
    wb_sel_o <= s;
    wb_dat_o <= d;
    do @(posedge clock); while (wb_ack_i !== 1'b1);
    q = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o <= 1'b0;
    @(posedge clock);
  endtask
endmodule

/* bench/test_erva_regs.sv */
// Self-checking bench for the register slice
`timescale 1ns/1ps
module test_erva_regs;
  import erva_pkg::*;
  localparam int LOAD_CYCLES = 3;
  localparam logic [127:0] HDR = 128'h0f0e0d0c_0b0a0908_07060504_03020100;
  localparam logic [127:0] TBL = 128'h89abcdef_01234567_fedcba98_76543210;
  logic clock = 0, reset = 1, power_on_reset = 1, second_channel_strap = 1;
  logic eeprom_load_valid = 0, err_valid = 0, err_masked = 0, err_log_release = 0;
  logic [2:0] eeprom_ext_count = 3'h0, eeprom_lp_count = 3'h0;
  logic [4:0] err_index = 5'h00;
  logic [127:0] err_header = 128'h0;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, err_message, ecrc_gen_enable;
  logic ecrc_check_enable, arb_cap_valid, table_load_busy;
  logic [11:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [2:0] arb_select;
  logic [127:0] arb_table_applied;
  int bad_count = 0, samples_checked = 0;
  erva_regs #(.LOAD_CYCLES(LOAD_CYCLES)) erva_regs_inst (.clock(clock), .reset(reset),
    .power_on_reset(power_on_reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .second_channel_strap(second_channel_strap),
    .eeprom_load_valid(eeprom_load_valid), .eeprom_ext_count(eeprom_ext_count),
    .eeprom_lp_count(eeprom_lp_count), .err_valid(err_valid), .err_index(err_index),
    .err_masked(err_masked), .err_header(err_header), .err_log_release(err_log_release),
    .err_message(err_message), .ecrc_gen_enable(ecrc_gen_enable),
    .ecrc_check_enable(ecrc_check_enable), .arb_select(arb_select),
    .arb_table_applied(arb_table_applied), .arb_cap_valid(arb_cap_valid),
    .table_load_busy(table_load_busy));
  erva_host_model erva_host_model_inst (.clock(clock), .wb_cyc_o(wb_cyc_i),
    .wb_stb_o(wb_stb_i), .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i),
    .wb_dat_o(wb_dat_i), .wb_ack_i(wb_ack_o), .wb_dat_i(wb_dat_o));
  initial forever #2 clock = ~clock;
  task automatic chk(input string n, input logic [127:0] e, input logic [127:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    erva_host_model_inst.xfer(1'b0, a, 4'h0, 32'h0, q);
    chk($sformatf("read %h", a), {96'h0, e}, {96'h0, q});
  endtask
  task automatic wr(input logic [11:0] a, input logic [3:0] s, input logic [31:0] d);
    erva_host_model_inst.xfer(1'b1, a, s, d, q);
  endtask
  task automatic err_pulse(input logic m, input logic [4:0] i, input logic [127:0] h,
                           input logic e);
    err_valid <= 1'b1;
    err_masked <= m;
    err_index <= i;
    err_header <= h;
    @(posedge clock);
    err_valid <= 1'b0;
    #1 chk("message", {127'h0, e}, {127'h0, err_message});
    @(posedge clock);
  endtask
  task automatic t_reset_values();
    rd(ERVA_ADV_ERR_CAP, 32'h0000_00a0);
    wr(ERVA_VC_CAP_HDR, 4'hf, 32'hffff_ffff);
    rd(ERVA_VC_CAP_HDR, 32'h20c1_0002);
    rd(ERVA_PORT_CAP_ONE, 32'h0000_0801);
    rd(ERVA_PORT_CAP_TWO, 32'h0300_0003);
    rd(ERVA_PORT_CTRL, 32'h0);
    rd(12'h200, 32'h0);
    chk("cap valid", 128'h0, {127'h0, arb_cap_valid});
  endtask
  task automatic t_ecrc();
    wr(ERVA_ADV_ERR_CAP, 4'h2, 32'hffff_ffff);
    rd(ERVA_ADV_ERR_CAP, 32'h0000_01a0);
    wr(ERVA_ADV_ERR_CAP, 4'hf, 32'hffff_ffff);
    chk("gen enable", 128'h1, {127'h0, ecrc_gen_enable});
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    rd(ERVA_ADV_ERR_CAP, 32'h0000_01e0);
    wr(ERVA_ADV_ERR_CAP, 4'hf, 32'h0);
    chk("check enable", 128'h0, {127'h0, ecrc_check_enable});
  endtask
  task automatic t_errlog();
    err_pulse(1'b1, 5'h07, ~HDR, 1'b0);
    rd(ERVA_ADV_ERR_CAP, 32'h0000_00a0);
    err_pulse(1'b0, 5'h0c, HDR, 1'b1);
    err_pulse(1'b0, 5'h03, ~HDR, 1'b1);
    rd(ERVA_ADV_ERR_CAP, 32'h0000_00ac);
    for (int i = 0; i < 4; i++) rd(ERVA_HDR_LOG0 + 12'(4 * i), HDR[32 * i +: 32]);
    err_log_release <= 1'b1;
    @(posedge clock);
    err_log_release <= 1'b0;
    err_pulse(1'b0, 5'h03, ~HDR, 1'b1);
    rd(ERVA_HDR_LOG3, ~HDR[127:96]);
    second_channel_strap <= 1'b0;
    power_on_reset <= 1'b1;
    repeat (2) @(posedge clock);
    power_on_reset <= 1'b0;
    @(posedge clock);
    rd(ERVA_ADV_ERR_CAP, 32'h0000_00a0);
    rd(ERVA_HDR_LOG0, 32'h0);
    rd(ERVA_PORT_CAP_ONE, 32'h0000_0800);
    rd(ERVA_PORT_CAP_TWO, 32'h0);
  endtask
  task automatic t_select();
    for (int v = 0; v < 8; v++) begin
      wr(ERVA_PORT_CTRL, 4'h1, {28'h0, 3'(v), 1'b0});
      rd(ERVA_PORT_CTRL, (v > 1) ? 32'h0 : 32'(2 * v));
    end
    wr(ERVA_PORT_CTRL, 4'h2, 32'h2);
    chk("select", 128'h0, {125'h0, arb_select});
  endtask
  task automatic t_load();
    for (int w = 0; w < 4; w++) wr(ERVA_ARB_TBL_BASE + 12'(4 * w), 4'hf, TBL[32 * w +: 32]);
    rd(ERVA_PORT_CTRL, 32'h0001_0000);
    wr(ERVA_PORT_CTRL, 4'h1, 32'h3);
    chk("busy", 128'h1, {127'h0, table_load_busy});
    rd(ERVA_PORT_CTRL, 32'h0001_0002);
    for (int i = 0; i < 50 && table_load_busy === 1'b1; i++) @(posedge clock);
    rd(ERVA_PORT_CTRL, 32'h0000_0002);
    chk("applied", TBL, arb_table_applied);
    rd(ERVA_ARB_TBL_LAST, TBL[127:96]);
  endtask
  task automatic t_autoload();
    eeprom_ext_count <= 3'h6;
    eeprom_lp_count <= 3'h2;
    eeprom_load_valid <= 1'b1;
    @(posedge clock);
    eeprom_load_valid <= 1'b0;
    @(posedge clock);
    chk("cap valid", 128'h1, {127'h0, arb_cap_valid});
    rd(ERVA_PORT_CAP_ONE, 32'h0000_0826);
    rd(ERVA_PORT_CAP_TWO, 32'h0);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    power_on_reset <= 1'b0;
    @(posedge clock);
    t_reset_values();
    t_ecrc();
    t_errlog();
    t_select();
    t_load();
    t_autoload();
    print_verdict();
  end
  // Whole run needs well under two thousand cycles
  initial begin
    #40000;
    bad_count++;
    print_verdict();
  end
endmodule
bind erva_regs erva_regs_checker #(.LOAD_CYCLES(LOAD_CYCLES)) erva_regs_checker_inst (
  .clock(clock), .reset(reset), .power_on_reset(power_on_reset), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .err_valid(err_valid), .err_masked(err_masked),
  .err_message(err_message), .ecrc_gen_enable(ecrc_gen_enable),
  .ecrc_check_enable(ecrc_check_enable), .arb_select(arb_select),
  .arb_table_applied(arb_table_applied), .table_load_busy(table_load_busy));
